// [dv/lpm_ctrl_props.sv]
// Concurrent checks on the ports of the latency and power management block.
// Assumes one clock, synchronous reset, and that the bench keeps adr[31:10] at 0.
module lpm_ctrl_props #(
    parameter int TGT_CLOCKS = 16,
    parameter int MST_CLOCKS = 8
) (
    input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic [31:0] wb_adr_i, wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        tgt_wait_i, isa_mst_wait_i, fast_dma_i, dt_timeout_i,
    input wire logic        port_rd_i, break_event_i, tgt_retry_o, isa_release_o,
    input wire logic        usb_release_o, delayed_txn_enable_o, serr_o,
    input wire logic        pci_hold_request_release_o, guaranteed_access_time_mode_o,
    input wire logic        cpu_clock_stop_n_o, system_mgmt_interrupt_out_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------
    // Shadow registers
    // ------------
    // Copies of the control bits, updated at the same edge as the design's.
    logic [3:0] lat_sh;
    logic [4:0] mgmt_sh;
    wire        take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        wr = take && wb_we_i && wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat_sh <= 4'h0;
            mgmt_sh <= 5'h08;
        end else if (wr && wb_adr_i[9:2] == 8'h82) begin
            lat_sh <= wb_dat_i[3:0];
        end else if (wr && wb_adr_i[9:2] == 8'ha0) begin
            mgmt_sh <= wb_dat_i[4:0];
        end
    end

    // ------------
    // Properties
    // ------------
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_tgt_start;
        $rose(tgt_wait_i) && delayed_txn_enable_o && !fast_dma_i;
    endsequence
    sequence s_isa_start;
        $rose(isa_mst_wait_i) && pci_hold_request_release_o && !fast_dma_i;
    endsequence

    bus_ack_a: assert property (take |=> s_ack_pulse)
        else $error("bus ack is not a single pulse after a request");
    tgt_latency_a: assert property (s_tgt_start |-> ##[0:TGT_CLOCKS]
        (tgt_retry_o || !tgt_wait_i || fast_dma_i)) else $error("target wait too long");
    mst_latency_a: assert property (s_isa_start |-> ##[0:MST_CLOCKS]
        (isa_release_o || !isa_mst_wait_i || fast_dma_i)) else $error("master wait too long");
    dma_unaffected_a: assert property (fast_dma_i |=>
        !(tgt_retry_o || isa_release_o || usb_release_o)) else $error("watchdog during DMA");
    gat_mode_off_a: assert property (
        guaranteed_access_time_mode_o == !pci_hold_request_release_o)
        else $error("access time mode not tied to passive release");
    serr_gate_a: assert property (!$past(rst_i) |->
        serr_o == ($past(dt_timeout_i) && $past(lat_sh[3]))) else $error("serr mismatch");
    usb_release_gate_a: assert property (!lat_sh[2] && !$past(lat_sh[2]) |->
        !usb_release_o) else $error("usb release while disabled");
    ctrl_bits_out_a: assert property (delayed_txn_enable_o == lat_sh[0] &&
        pci_hold_request_release_o == lat_sh[1]) else $error("enable outputs differ");
    stop_on_port_a: assert property (port_rd_i && mgmt_sh[1] && !break_event_i |=>
        !cpu_clock_stop_n_o) else $error("port read did not stop clock");
    stop_negated_a: assert property (!mgmt_sh[1] && !$past(mgmt_sh[1]) &&
        !$past(mgmt_sh[1], 2) |-> cpu_clock_stop_n_o) else $error("clock stop while off");
    smi_masked_a: assert property (!mgmt_sh[0] |-> system_mgmt_interrupt_out_n_o)
        else $error("management interrupt while masked");
endmodule

bind lpm_ctrl lpm_ctrl_props #(.TGT_CLOCKS(TGT_CLOCKS), .MST_CLOCKS(MST_CLOCKS)) u_props (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .tgt_wait_i, .isa_mst_wait_i, .fast_dma_i, .dt_timeout_i, .port_rd_i,
    .break_event_i, .tgt_retry_o, .isa_release_o, .usb_release_o, .delayed_txn_enable_o,
    .serr_o, .pci_hold_request_release_o, .guaranteed_access_time_mode_o,
    .cpu_clock_stop_n_o, .system_mgmt_interrupt_out_n_o);

// [dv/lpm_far_model.sv]
// Far-side agents: a PCI initiator, an ISA master and a USB master.
// Assumes the bench starts each agent with a one-cycle pulse on start_i.
module lpm_far_model #(
    parameter int SLOW = 24
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] start_i,
    input  wire logic [2:0] answer_i,
    output logic      [2:0] wait_o
);
    int cnt [3];

    // Each agent keeps waiting until answered or its slow cycle ends; an
    // agent gives up early only when answer_i is high; reset also clears wait_o.
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 3; i++) begin
            if (rst_i) begin
                wait_o[i] <= 1'b0;
                cnt[i] <= 0;
            end else if (start_i[i]) begin
                wait_o[i] <= 1'b1;
                cnt[i] <= 0;
            end else if (wait_o[i]) begin
                cnt[i] <= cnt[i] + 1;
                if (answer_i[i] || cnt[i] == SLOW) begin
                    wait_o[i] <= 1'b0;
                end
            end
        end
    end
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the latency and power management control block.
// Assumes lpm_ctrl, its header, the checker and the far-side model.
`include "lpm_regs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, fast_dma_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, r, exp_q [$];
    logic [3:0]  wb_sel_i = 4'h1, ev = 4'h0;
    logic [2:0]  start = 3'h0;
    wire  [31:0] wb_dat_o;
    wire  [2:0]  wt, rel;
    wire         wb_ack_o, serr_o, stop_n, smi_n, irq_o;
    int          fails = 0, check_count = 0, n, tick;

    // Free-running bus clock, 20 ns period.
    always #10 clk_i = ~clk_i;

    lpm_ctrl #(.MSEC_CYCLES(4), .MINUTE_CYCLES(10)) dut (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .tgt_wait_i(wt[0]), .isa_mst_wait_i(wt[1]),
        .usb_mst_wait_i(wt[2]), .fast_dma_i, .dt_timeout_i(ev[0]), .port_wr_i(ev[1]),
        .port_rd_i(ev[2]), .break_event_i(ev[3]), .sys_activity_i(1'b0),
        .tgt_retry_o(rel[0]), .isa_release_o(rel[1]), .usb_release_o(rel[2]),
        .delayed_txn_enable_o(), .pci_hold_request_release_o(),
        .guaranteed_access_time_mode_o(), .serr_o, .cpu_clock_stop_n_o(stop_n),
        .system_mgmt_interrupt_out_n_o(smi_n), .irq_o);

    lpm_far_model #(.SLOW(24)) far (.clk_i, .rst_i, .start_i(start), .answer_i(rel),
        .wait_o(wt));

    // ------------
    // Tasks
    // ------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            fails++;
            $display("ERROR %0t ns: saw %h, expected %h", $time, seen, want);
        end
    endtask

    // The request stands until the rising edge that samples ack high.
    task automatic wb(input logic [7:0] idx, input logic we, input logic [7:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {22'h0, idx, 2'h0};
        wb_dat_i <= {24'h0, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        chk(wb_ack_o, 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        wb(idx, 1'b0, 8'h00);
    endtask

    // One-cycle event pulse; returns at a falling edge with results settled.
    task automatic pulse(input logic [3:0] m);
        @(posedge clk_i);
        ev <= m;
        @(posedge clk_i);
        ev <= 4'h0;
        @(negedge clk_i);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Read data is taken at the edge that samples ack high.
    always @(posedge clk_i)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            chk(wb_dat_o, exp_q.pop_front());

    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        tally_and_finish();
    end

    // ------------
    // Scenarios
    // ------------
    initial begin
        void'($urandom(7));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`LPM_IDX_LAT_CTRL, 8'h00);
        rd(`LPM_IDX_MGMT_CTRL, 8'h08);
        repeat (4) begin
            r = $urandom;
            wb(`LPM_IDX_LAT_CTRL, 1'b1, r[7:0]);
            wb(`LPM_IDX_MGMT_CTRL, 1'b1, r[15:8]);
            wb(8'h10, 1'b1, r[23:16]);
            rd(`LPM_IDX_LAT_CTRL, r[7:0] & 8'h0f);
            rd(`LPM_IDX_MGMT_CTRL, r[15:8] & 8'h1f);
            rd(8'h10, 8'h00);
        end
        wb(`LPM_IDX_MGMT_CTRL, 1'b1, 8'h08);
        // Watchdogs: enabled, disabled, and enabled during a DMA burst.
        for (int m = 0; m < 3; m++) begin
            for (int i = 0; i < 3; i++) begin
                wb(`LPM_IDX_LAT_CTRL, 1'b1, (m == 1) ? 8'h00 : 8'h07);
                fast_dma_i <= (m == 2);
                @(posedge clk_i);
                start <= 3'h1 << i;
                @(posedge clk_i);
                start <= 3'h0;
                n = 0;
                while (rel[i] !== 1'b1 && n < 30) begin
                    @(negedge clk_i);
                    n++;
                end
                chk(32'(n <= ((i == 0) ? 16 : 8)), 32'(m == 0));
                repeat (30) @(posedge clk_i);
                fast_dma_i <= 1'b0;
            end
        end
        // System error on a delayed transaction timeout, gated by its bit.
        for (int e = 0; e < 2; e++) begin
            wb(`LPM_IDX_LAT_CTRL, 1'b1, {4'h0, e[0], 3'h0});
            pulse(4'h1);
            chk(serr_o, e[0]);
        end
        // Sticky status, mask and level interrupt; the gate bit is then set to drive the pin.
        wb(`LPM_IDX_IRQ_STAT, 1'b1, 8'h07);
        wb(`LPM_IDX_IRQ_MASK, 1'b1, 8'h02);
        pulse(4'h2);
        chk(irq_o, 1'b1);
        chk(smi_n, 1'b1);
        wb(`LPM_IDX_MGMT_CTRL, 1'b1, 8'h09);
        chk(smi_n, 1'b0);
        wb(`LPM_IDX_IRQ_MASK, 1'b1, 8'h00);
        chk(irq_o, 1'b0);
        rd(`LPM_IDX_IRQ_STAT, 8'h02);
        wb(`LPM_IDX_IRQ_STAT, 1'b1, 8'h02);
        rd(`LPM_IDX_IRQ_STAT, 8'h00);
        // Idle timer in every granularity; the timer is stopped before a load.
        wb(`LPM_IDX_IRQ_MASK, 1'b1, 8'h01);
        for (int g = 0; g < 4; g++) begin
            wb(`LPM_IDX_MGMT_CTRL, 1'b1, 8'h08);
            wb(`LPM_IDX_IDLE_CNT, 1'b1, 8'h03);
            wb(`LPM_IDX_IRQ_STAT, 1'b1, 8'h07);
            wb(`LPM_IDX_MGMT_CTRL, 1'b1, {3'h0, g[1:0], 3'h0});
            tick = (g == 0) ? 10 : (g == 3) ? 4 : 1;
            n = 0;
            while (irq_o !== 1'b1 && n < 80) begin
                @(negedge clk_i);
                n++;
            end
            if (g == 1)
                chk(n, 80);
            else
                chk(32'(n >= tick && n <= 4 * tick + 6), 1);
        end
        // Clock stop: port read, break event, then scaled low time.
        wb(`LPM_IDX_MGMT_CTRL, 1'b1, 8'h0a);
        pulse(4'h4);
        chk(stop_n, 1'b0);
        pulse(4'h8);
        chk(stop_n, 1'b1);
        wb(`LPM_IDX_STOP_HIGH, 1'b1, 8'h01);
        wb(`LPM_IDX_STOP_LOW, 1'b1, 8'h02);
        wb(`LPM_IDX_MGMT_CTRL, 1'b1, 8'h0e);
        pulse(4'h4);
        n = 0;
        while (stop_n === 1'b0 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        chk(n, 3);
        wb(`LPM_IDX_MGMT_CTRL, 1'b1, 8'h08);
        repeat (2) @(negedge clk_i);
        chk(stop_n, 1'b1);
        tally_and_finish();
    end
endmodule

// [verilog/lpm_ctrl.sv]
// Latency compliance and power management control registers with their
// watchdogs, idle timer, clock-stop sequencer and management interrupt.
// Assumes all status inputs come from logic on clk_i, so none is synced.
//
// Operation
// - Target answers within 16 clocks, using delayed completion.
// - Master data phase ready within 8 clocks.
// - IDE and fast DMA traffic stay unaffected.
// - Passive release disables guaranteed access time mode.
// - Bit 3 raises system error on timeout.
// - Bit 2 enables USB passive release.
// - Bit 1 enables passive release on hold.
// - Bit 0 enables delayed transactions as target.
// - Bits 4:3 select idle timer granularity.
// - Granularity counted in bus clocks, scales with rate.
// - Scaling uses high and low timer registers.
// - Command port read asserts clock stop.
// - Clock stop negated while its enable clear.
// - Bit 0 only gates the interrupt output.
// - Idle timer expiry raises management request.
`include "lpm_regs.svh"

module lpm_ctrl #(
    parameter int unsigned MSEC_CYCLES   = `LPM_MSEC_CYCLES,
    parameter int unsigned MINUTE_CYCLES = `LPM_MINUTE_CYCLES,
    parameter int unsigned TGT_CLOCKS    = `LPM_TGT_CLOCKS,
    parameter int unsigned MST_CLOCKS    = `LPM_MST_CLOCKS
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        tgt_wait_i,
    input  wire logic        isa_mst_wait_i,
    input  wire logic        usb_mst_wait_i,
    input  wire logic        fast_dma_i,
    input  wire logic        dt_timeout_i,
    input  wire logic        port_rd_i,
    input  wire logic        port_wr_i,
    input  wire logic        break_event_i,
    input  wire logic        sys_activity_i,
    output logic             tgt_retry_o,
    output logic             isa_release_o,
    output logic             usb_release_o,
    output logic             delayed_txn_enable_o,
    output logic             pci_hold_request_release_o,
    output logic             guaranteed_access_time_mode_o,
    output logic             serr_o,
    output logic             cpu_clock_stop_n_o,
    output logic             system_mgmt_interrupt_out_n_o,
    output logic             irq_o
);

    // ------------
    // Register state.
    // ------------
    lpm_pkg::lpm_lat_ctrl_t  lat_reg;
    lpm_pkg::lpm_mgmt_ctrl_t mgmt_reg;
    lpm_pkg::lpm_cs_state_t  cs_reg;
    lpm_pkg::lpm_cs_state_t  cs_next;
    logic [7:0]              idle_load_reg;
    logic [7:0]              idle_cnt_reg;
    logic [31:0]             pre_reg;
    logic [7:0]              stat_reg;
    logic [7:0]              stat_next;
    logic [7:0]              mask_reg;
    logic [7:0]              stop_high_reg;
    logic [7:0]              stop_low_reg;
    logic [7:0]              cs_cnt_reg;
    logic                    ack_reg;
    logic [31:0]             rdat_reg;
    logic                    serr_reg;
    logic [2:0]              wd_fire;
    logic                    take;
    logic                    wr;
    logic                    hit_word;
    logic [7:0]              idx;
    logic [7:0]              wdat;
    logic                    tick;
    logic                    idle_event;
    logic [7:0]              events;
    logic                    pending;

    // ------------
    // Wishbone decode.
    // ------------
    // A request is taken once; ack follows one cycle later and drops after.
    assign take     = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr       = take & wb_we_i & wb_sel_i[0];
    assign hit_word = (wb_adr_i[31:10] == 22'h0);
    assign idx      = wb_adr_i[9:2];
    assign wdat     = wb_dat_i[7:0];
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // Acknowledge every taken request, mapped or not.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= take;
        end
    end

    // Read data mux; unmapped words and reserved bits read as zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_reg <= 32'h0;
        end else if (take) begin
            rdat_reg <= 32'h0;
            if (hit_word) begin
                case (idx)
                    `LPM_IDX_LAT_CTRL:  rdat_reg[7:0] <= lat_reg;
                    `LPM_IDX_MGMT_CTRL: rdat_reg[7:0] <= mgmt_reg;
                    `LPM_IDX_IDLE_CNT:  rdat_reg[7:0] <= idle_load_reg;
                    `LPM_IDX_IRQ_STAT:  rdat_reg[7:0] <= stat_reg;
                    `LPM_IDX_IRQ_MASK:  rdat_reg[7:0] <= mask_reg;
                    `LPM_IDX_STOP_HIGH: rdat_reg[7:0] <= stop_high_reg;
                    `LPM_IDX_STOP_LOW:  rdat_reg[7:0] <= stop_low_reg;
                    default:            rdat_reg <= 32'h0;
                endcase
            end
        end
    end

    // ------------
    // Control registers.
    // ------------
    // Writes to reserved positions are masked off so they always read zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat_reg <= `LPM_RST_LAT_CTRL;
        end else if (wr && hit_word && idx == `LPM_IDX_LAT_CTRL) begin
            lat_reg <= wdat & `LPM_WMASK_LAT;
        end
    end

    // The clock-stop enable is cleared simply by writing a zero to it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mgmt_reg <= `LPM_RST_MGMT_CTRL;
        end else if (wr && hit_word && idx == `LPM_IDX_MGMT_CTRL) begin
            mgmt_reg <= wdat & `LPM_WMASK_MGMT;
        end
    end

    // Idle count, mask and the two clock-stop scaling timers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idle_load_reg <= `LPM_RST_IDLE_CNT;
            mask_reg      <= 8'h00;
            stop_high_reg <= 8'h00;
            stop_low_reg  <= 8'h00;
        end else if (wr && hit_word) begin
            case (idx)
                `LPM_IDX_IDLE_CNT:  idle_load_reg <= wdat;
                `LPM_IDX_IRQ_MASK:  mask_reg      <= wdat & `LPM_WMASK_IRQ;
                `LPM_IDX_STOP_HIGH: stop_high_reg <= wdat;
                `LPM_IDX_STOP_LOW:  stop_low_reg  <= wdat;
                default: begin
                end
            endcase
        end
    end

    // ------------
    // Bus mode outputs.
    // ------------
    // These are plain levels taken straight from the control register.
    assign delayed_txn_enable_o          = lat_reg.delayed_txn;
    assign pci_hold_request_release_o    = lat_reg.passive_release;
    // Guaranteed access time cannot coexist with passive release.
    assign guaranteed_access_time_mode_o = ~lat_reg.passive_release;

    // ------------
    // Latency watchdogs: target, ISA master and USB master.
    // ------------
    // Each channel counts wait cycles and fires one cycle before its bound,
    // so the registered pulse lands inside the allowed window.
    generate
        for (genvar ch = 0; ch < 3; ch++) begin : g_wd
            localparam int unsigned LIM = (ch == 0) ? TGT_CLOCKS : MST_CLOCKS;
            logic [4:0] cnt_reg;
            logic       wait_in;
            logic       en;
            logic       fire_reg;
            always_comb begin
                case (ch)
                    0: begin
                        wait_in = tgt_wait_i;
                        en      = lat_reg.delayed_txn;
                    end
                    1: begin
                        wait_in = isa_mst_wait_i;
                        en      = lat_reg.passive_release;
                    end
                    default: begin
                        wait_in = usb_mst_wait_i;
                        en      = lat_reg.usb_bus_release_enable;
                    end
                endcase
            end
            // Fast DMA traffic is never cut short by either mechanism.
            always_ff @(posedge clk_i) begin
                if (rst_i || !wait_in || fast_dma_i) begin
                    cnt_reg  <= 5'd0;
                    fire_reg <= 1'b0;
                end else begin
                    cnt_reg  <= cnt_reg + 5'd1;
                    fire_reg <= en && (cnt_reg == 5'(LIM - 2));
                end
            end
            assign wd_fire[ch] = fire_reg;
        end
    endgenerate

    assign tgt_retry_o   = wd_fire[0];
    assign isa_release_o = wd_fire[1];
    assign usb_release_o = wd_fire[2];

    // ------------
    // System error on delayed transaction timeout.
    // ------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serr_reg <= 1'b0;
        end else begin
            serr_reg <= dt_timeout_i & lat_reg.serr_on_timeout;
        end
    end
    assign serr_o = serr_reg;

    // ------------
    // Idle timer prescaler.
    // ------------
    // Granularity is a count of bus clocks, so a slower clock stretches
    // the minute and millisecond steps in proportion.
    always_comb begin
        case (mgmt_reg.idle_timer_granularity)
            `LPM_GRAN_CLOCK:  tick = 1'b1;
            `LPM_GRAN_MSEC:   tick = (pre_reg == 32'(MSEC_CYCLES - 1));
            `LPM_GRAN_MINUTE: tick = (pre_reg == 32'(MINUTE_CYCLES - 1));
            default:          tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || tick ||
            mgmt_reg.idle_timer_granularity == `LPM_GRAN_OFF) begin
            pre_reg <= 32'h0;
        end else begin
            pre_reg <= pre_reg + 32'h1;
        end
    end

    // ------------
    // Idle timer count.
    // ------------
    // While frozen the counter tracks the load value; software is expected
    // to freeze it before changing that value.
    assign idle_event = tick && (idle_cnt_reg <= 8'h01);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idle_cnt_reg <= `LPM_RST_IDLE_CNT;
        end else if (mgmt_reg.idle_timer_granularity == `LPM_GRAN_OFF ||
                     sys_activity_i || idle_event) begin
            idle_cnt_reg <= idle_load_reg;
        end else if (tick) begin
            idle_cnt_reg <= idle_cnt_reg - 8'h01;
        end
    end

    // ------------
    // Request status and interrupt output.
    // ------------
    always_comb begin
        events                  = 8'h00;
        events[`LPM_EV_IDLE]    = idle_event;
        events[`LPM_EV_PORT_WR] = port_wr_i;
        events[`LPM_EV_DT_TMO]  = dt_timeout_i;
    end

    // A new event wins over a write-one-to-clear in the same cycle.
    always_comb begin
        stat_next = stat_reg;
        if (wr && hit_word && idx == `LPM_IDX_IRQ_STAT) begin
            stat_next = stat_reg & ~(wdat & `LPM_WMASK_IRQ);
        end
        stat_next = stat_next | events;
    end

    // Recording runs regardless of the output enable.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_reg <= 8'h00;
        end else begin
            stat_reg <= stat_next;
        end
    end

    assign pending                       = |(stat_reg & mask_reg);
    assign irq_o                         = pending;
    // The enable gates only the pin, never the recorded status.
    assign system_mgmt_interrupt_out_n_o = ~(pending & mgmt_reg.smi_enable);

    // ------------
    // Clock-stop sequencer.
    // ------------
    // Without scaling the stop holds until a break event or a cleared enable; with scaling it
    // alternates low and high phases set by the two timer registers.
    always_comb begin
        cs_next = cs_reg;
        case (cs_reg)
            lpm_pkg::LPM_CS_RUN: begin
                if (port_rd_i && mgmt_reg.clock_stop_output_enable) begin
                    cs_next = lpm_pkg::LPM_CS_STOP;
                end
            end
            lpm_pkg::LPM_CS_STOP: begin
                if (!mgmt_reg.clock_stop_output_enable || break_event_i) begin
                    cs_next = lpm_pkg::LPM_CS_RUN;
                end else if (mgmt_reg.clock_stop_scaling_enable &&
                             cs_cnt_reg == 8'h00) begin
                    cs_next = lpm_pkg::LPM_CS_HIGH;
                end
            end
            lpm_pkg::LPM_CS_HIGH: begin
                if (!mgmt_reg.clock_stop_output_enable || break_event_i) begin
                    cs_next = lpm_pkg::LPM_CS_RUN;
                end else if (!mgmt_reg.clock_stop_scaling_enable) begin
                    cs_next = lpm_pkg::LPM_CS_STOP;
                end else if (cs_cnt_reg == 8'h00) begin
                    cs_next = lpm_pkg::LPM_CS_STOP;
                end
            end
            default: cs_next = lpm_pkg::LPM_CS_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_reg <= lpm_pkg::LPM_CS_RUN;
        end else begin
            cs_reg <= cs_next;
        end
    end

    // Phase counter reloads on every phase change and counts down inside it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_cnt_reg <= 8'h00;
        end else if (cs_next != cs_reg) begin
            cs_cnt_reg <= (cs_next == lpm_pkg::LPM_CS_HIGH) ?
                          stop_high_reg : stop_low_reg;
        end else if (cs_cnt_reg != 8'h00) begin
            cs_cnt_reg <= cs_cnt_reg - 8'h01;
        end
    end

    // Active low: low only in the stop phase, high otherwise.
    assign cpu_clock_stop_n_o = (cs_reg != lpm_pkg::LPM_CS_STOP);

endmodule

// [verilog/lpm_pkg.sv]
// Types of the latency and power management control block.
// Assumes lpm_regs.svh is compiled alongside for the numeric constants.
package lpm_pkg;

    // ------------
    // Register layouts.
    // ------------
    typedef struct packed {
        logic [3:0] rsvd;
        logic       serr_on_timeout;
        logic       usb_bus_release_enable;
        logic       passive_release;
        logic       delayed_txn;
    } lpm_lat_ctrl_t;

    typedef struct packed {
        logic [2:0] rsvd;
        logic [1:0] idle_timer_granularity;
        logic       clock_stop_scaling_enable;
        logic       clock_stop_output_enable;
        logic       smi_enable;
    } lpm_mgmt_ctrl_t;

    // ------------
    // Clock-stop sequencer states.
    // ------------
    typedef enum logic [2:0] {
        LPM_CS_RUN  = 3'b001,
        LPM_CS_STOP = 3'b010,
        LPM_CS_HIGH = 3'b100
    } lpm_cs_state_t;

endpackage

// [verilog/lpm_regs.svh]
// Offsets, field positions, reset values and timing counts of the latency
// and power management control block.
// Assumes a 32-bit Wishbone bus where each register index is one word.
`ifndef LPM_REGS_SVH
`define LPM_REGS_SVH

// ------------
// Register indices; byte address is four times the index.
// ------------
`define LPM_IDX_LAT_CTRL   8'h82
`define LPM_IDX_MGMT_CTRL  8'ha0
`define LPM_IDX_IDLE_CNT   8'ha8
`define LPM_IDX_IRQ_STAT   8'hc0
`define LPM_IDX_IRQ_MASK   8'hc4
`define LPM_IDX_STOP_HIGH  8'hc8
`define LPM_IDX_STOP_LOW   8'hc9

// ------------
// Reset values and writable bit masks.
// ------------
`define LPM_RST_LAT_CTRL   8'h00
`define LPM_RST_MGMT_CTRL  8'h08
`define LPM_RST_IDLE_CNT   8'h0f
`define LPM_WMASK_LAT      8'h0f
`define LPM_WMASK_MGMT     8'h1f
`define LPM_WMASK_IRQ      8'h07

// ------------
// Field positions and idle timer granularity codes.
// ------------
`define LPM_EV_IDLE        0
`define LPM_EV_PORT_WR     1
`define LPM_EV_DT_TMO      2
`define LPM_GRAN_MINUTE    2'b00
`define LPM_GRAN_OFF       2'b01
`define LPM_GRAN_CLOCK     2'b10
`define LPM_GRAN_MSEC      2'b11

// ------------
// Timing: counts derived from the nominal bus clock rate.
// ------------
`define LPM_PCI_MHZ        33
`define LPM_MSEC_US        1000
`define LPM_MINUTE_S       60
`define LPM_MSEC_CYCLES    (`LPM_MSEC_US * `LPM_PCI_MHZ)
`define LPM_MINUTE_CYCLES  (32'd60 * 32'd1000000 * 32'd33)
`define LPM_TGT_CLOCKS     16
`define LPM_MST_CLOCKS     8

`endif
